// file: include/mpt_regs.svh
// Register map, field positions and counts of the modulator/PWM timer.
// Assumes an AXI4-Lite slave addressing one 32-bit word per register.
//
// Contract
// (R1) 8-bit down counter, reload register at 0CF
// (R2) Three control bits in control_reg_two select function
// (R3) Modulator clock: osc when clk_sel, else tc
// (R4) Instruction clock is oscillator divided by ten
// (R5) Software writes n-1 for n pulses
// (R6) Modulator passes pulses; underflow stops, pin low
// (R7) Setting mod_run loads counter from reload
// (R8) Clearing mod_run stops the counter
// (R9) Fifty-percent mode toggles pin each underflow
// (R10) Wide timer underflow sets run, pin high
// (R11) Variable duty underflow clears run, pin low
// (R12) Software sets wide timer mode 101
// (R13) Reset clears all three control bits
// (R14) Software makes the pin an output first
// (R15) Wide timer auto-reloads at instruction rate
// (R16) Decrement per tick, underflow from zero
`ifndef MPT_REGS_SVH
`define MPT_REGS_SVH
`define MPT_IDX_CTRL     8'hcc
`define MPT_IDX_RELOAD   8'hcf
`define MPT_IDX_TMR_RL   8'hd0
`define MPT_IDX_TMR_CTRL 8'hd1
`define MPT_IDX_STATUS   8'hd2
`define MPT_BIT_RUN      0
`define MPT_BIT_CLK_SEL  1
`define MPT_BIT_MODE_SEL 2
`define MPT_TMR_RUN      4
`define MPT_TMR_AUTO     3'h4
`define MPT_TMR_TOGGLE   3'h5
`define MPT_RST_RELOAD   8'h00
`define MPT_RST_TMR_RL   16'h0000
`define MPT_RST_TMR_CTRL 8'h00
`define MPT_TC_DIV       10
`endif

// file: include/mpt_pkg.sv
// Types shared by the modulator/PWM timer files.
// Assumes mpt_regs.svh supplies the numeric constants.
package mpt_pkg;
  typedef enum logic [1:0] {
    MPT_IO   = 2'b00,
    MPT_HALF = 2'b01,
    MPT_VAR  = 2'b10,
    MPT_MOD  = 2'b11
  } mpt_mode_e;

  typedef struct packed {
    logic mode_sel;
    logic clk_sel;
    logic run;
  } mpt_ctrl_s;
endpackage

// file: logic/mpt_tc_div.sv
// Instruction-cycle divider: one-cycle tick every TC_DIV clocks.
// Assumes clk is the oscillator clock itself.
`timescale 1ns/1ps
`default_nettype none
`include "mpt_regs.svh"
module mpt_tc_div
  import mpt_pkg::*;
#(
  parameter int TC_DIV = `MPT_TC_DIV
) (
  input  wire logic clk,
  input  wire logic srst,
  output logic      tc_tick,
  output logic      tc_hi
);
  logic [3:0] cnt_r;

  always_ff @(posedge clk) begin
    if (srst || tc_tick) cnt_r <= 4'h0;
    else cnt_r <= cnt_r + 4'h1;
  end

  assign tc_tick = (cnt_r == 4'(TC_DIV - 1)); // R4
  // First half of each period counts as the high phase of tc
  assign tc_hi   = (cnt_r < 4'(TC_DIV / 2));
endmodule
`default_nettype wire

// file: logic/mpt_wide_timer.sv
// 16-bit auto-reload timer seen by the modulator only via its underflow.
// Assumes tick is the one-cycle instruction-rate enable.
`timescale 1ns/1ps
`default_nettype none
module mpt_wide_timer
  import mpt_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         tick,
  input  wire logic         en,
  input  wire logic         toggle,
  input  wire logic [W-1:0] reload,
  output logic              uflow,
  output logic              timer_io_pin
);
  logic [W-1:0] cnt_r;

  assign uflow = en && tick && (cnt_r == '0);

  always_ff @(posedge clk) begin
    if (srst || !en) cnt_r <= reload;
    else if (uflow) cnt_r <= reload; // R15
    else if (tick) cnt_r <= cnt_r - W'(1);
  end

  always_ff @(posedge clk) begin
    if (srst) timer_io_pin <= 1'b0;
    else if (uflow && toggle) timer_io_pin <= ~timer_io_pin;
  end
endmodule
`default_nettype wire

// file: logic/mpt_top.sv
// Modulator/PWM timer with AXI4-Lite register slave.
// Assumes clk is the oscillator; the pin is a two-way pad outside.
`timescale 1ns/1ps
`default_nettype none
`include "mpt_regs.svh"
module mpt_top
  import mpt_pkg::*;
#(
  parameter int AW = 12
) (
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          gpio_o,
  input  wire logic          gpio_oe,
  input  wire logic          mod_out_pin_i,
  output logic               mod_out_pin_o,
  output logic               mod_out_pin_oe,
  output logic               timer_io_pin_o
);
  function automatic logic [7:0] reg_idx(input logic [AW-1:0] a);
    return a[9:2];
  endfunction

  function automatic logic idx_ok(input logic [7:0] i);
    return (i == `MPT_IDX_CTRL) || (i == `MPT_IDX_RELOAD) ||
           (i == `MPT_IDX_TMR_RL) || (i == `MPT_IDX_TMR_CTRL) ||
           (i == `MPT_IDX_STATUS);
  endfunction

  // ---------------- AXI4-Lite write path ----------------
  logic          aw_got_r;
  logic          w_got_r;
  logic [AW-1:0] aw_addr_r;
  logic [31:0]   w_data_r;
  logic [3:0]    w_strb_r;
  logic          bvalid_r;
  logic [1:0]    bresp_r;

  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs  = s_axi_wvalid && s_axi_wready;
  wire [AW-1:0] wr_addr = aw_got_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0]   wr_data = w_got_r ? w_data_r : s_axi_wdata;
  wire [3:0]    wr_strb = w_got_r ? w_strb_r : s_axi_wstrb;
  wire have_aw = aw_got_r || aw_hs;
  wire have_w  = w_got_r || w_hs;
  wire wr_go   = have_aw && have_w && !bvalid_r;
  wire [7:0] wr_idx = reg_idx(wr_addr);
  wire wr_ok   = idx_ok(wr_idx);
  // Every 8-bit register sits on byte lane 0; other lanes are dropped
  wire wr_b0   = wr_go && wr_strb[0];
  wire wr_ctrl = wr_b0 && (wr_idx == `MPT_IDX_CTRL);
  wire wr_rl   = wr_b0 && (wr_idx == `MPT_IDX_RELOAD);
  wire wr_tctl = wr_b0 && (wr_idx == `MPT_IDX_TMR_CTRL);
  wire wr_trl  = wr_go && (wr_idx == `MPT_IDX_TMR_RL);

  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  always_ff @(posedge clk) begin
    if (srst || wr_go) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
    end else begin
      if (aw_hs) aw_got_r <= 1'b1;
      if (w_hs) w_got_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (aw_hs) aw_addr_r <= s_axi_awaddr;
    if (w_hs) w_data_r <= s_axi_wdata;
    if (w_hs) w_strb_r <= s_axi_wstrb;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= 2'h0;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_ok ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ---------------- Block state ----------------
  mpt_ctrl_s   ctrl_r;
  mpt_ctrl_s   ctrl_nxt;
  logic [7:0]  reload_r;
  logic [7:0]  cnt_r;
  logic [7:0]  cnt_nxt;
  logic        pin_r;
  logic        pin_nxt;
  logic        oe_r;
  logic [15:0] tmr_rl_r;
  logic [7:0]  tmr_ctrl_r;
  logic        pin_s1_r;
  logic        pin_s2_r;
  logic        tc_tick;
  logic        tc_hi;
  logic        wt_uflow;

  mpt_tc_div u_div (
    .clk     (clk),
    .srst    (srst),
    .tc_tick (tc_tick),
    .tc_hi   (tc_hi)
  );

  wire [2:0] tmode = tmr_ctrl_r[7:5];
  wire t_en  = tmr_ctrl_r[`MPT_TMR_RUN] &&
               ((tmode == `MPT_TMR_AUTO) || (tmode == `MPT_TMR_TOGGLE));

  mpt_wide_timer u_wt (
    .clk    (clk),
    .srst   (srst),
    .tick   (tc_tick),
    .en     (t_en),
    .toggle (tmode == `MPT_TMR_TOGGLE),
    .reload (tmr_rl_r),
    .uflow  (wt_uflow),
    .timer_io_pin    (timer_io_pin_o)
  );

  // Mode follows the bit table; run only matters in the all-clear case
  function automatic mpt_mode_e mode_of(input mpt_ctrl_s c);
    if (c.mode_sel) return MPT_MOD;
    else if (c.clk_sel) return MPT_VAR;
    else if (c.run) return MPT_HALF;
    else return MPT_IO;
  endfunction

  wire mpt_mode_e mode = mode_of(ctrl_r); // R2
  wire tick = (mode == MPT_MOD && ctrl_r.clk_sel) ? 1'b1 : tc_tick; // R3
  wire uflow = ctrl_r.run && tick && (cnt_r == 8'h00); // R16
  wire var_set = (mode == MPT_VAR) && wt_uflow;
  // Writing run while already running must not reload the count
  wire sw_set = wr_ctrl && wr_data[`MPT_BIT_RUN] && !ctrl_r.run;
  wire start = sw_set || var_set; // R7

  always_comb begin
    ctrl_nxt = ctrl_r;
    // Free-running half mode never stops on its own
    if (uflow && mode != MPT_HALF) ctrl_nxt.run = 1'b0; // R6 R11
    if (wr_ctrl) begin
      ctrl_nxt.run      = wr_data[`MPT_BIT_RUN]; // R8
      ctrl_nxt.clk_sel  = wr_data[`MPT_BIT_CLK_SEL];
      ctrl_nxt.mode_sel = wr_data[`MPT_BIT_MODE_SEL];
    end
    // A timer underflow beats a clear landing in the same cycle
    if (var_set) ctrl_nxt.run = 1'b1; // R10
  end

  always_comb begin
    cnt_nxt = cnt_r;
    if (start) cnt_nxt = reload_r; // R7
    else if (uflow) cnt_nxt = (mode == MPT_HALF) ? reload_r : 8'h00; // R9
    else if (ctrl_r.run && tick) cnt_nxt = cnt_r - 8'h01; // R16
  end

  always_comb begin
    pin_nxt = pin_r;
    case (mode_of(ctrl_nxt))
      MPT_IO:   pin_nxt = gpio_o; // R13
      // OSC_INPUT_CLOCK carrier is shown as a steady high for the burst length
      MPT_MOD:  pin_nxt = ctrl_nxt.run && (ctrl_nxt.clk_sel || tc_hi); // R6
      MPT_HALF: pin_nxt = uflow ? ~pin_r : pin_r; // R9
      MPT_VAR: begin
        if (var_set) pin_nxt = 1'b1; // R10
        else if (!ctrl_nxt.run) pin_nxt = 1'b0; // R11
      end
      default:  pin_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r <= '0; // R13
      cnt_r  <= 8'h00;
      pin_r  <= 1'b0;
      oe_r   <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      cnt_r  <= cnt_nxt;
      pin_r  <= pin_nxt;
      // Any timer mode owns the pad, whatever gpio_oe says
      oe_r   <= (mode_of(ctrl_nxt) == MPT_IO) ? gpio_oe : 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reload_r   <= `MPT_RST_RELOAD;
      tmr_rl_r   <= `MPT_RST_TMR_RL;
      tmr_ctrl_r <= `MPT_RST_TMR_CTRL;
    end else begin
      if (wr_rl) reload_r <= wr_data[7:0]; // R1
      if (wr_tctl) tmr_ctrl_r <= wr_data[7:0];
      if (wr_trl && wr_strb[0]) tmr_rl_r[7:0] <= wr_data[7:0];
      if (wr_trl && wr_strb[1]) tmr_rl_r[15:8] <= wr_data[15:8];
    end
  end

  // The pad is asynchronous: two flops before the status word reads it
  always_ff @(posedge clk) begin
    pin_s1_r <= mod_out_pin_i;
    pin_s2_r <= pin_s1_r;
  end

  assign mod_out_pin_o  = pin_r;
  assign mod_out_pin_oe = oe_r;

  // ---------------- AXI4-Lite read path ----------------
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  wire [7:0] rd_idx = reg_idx(s_axi_araddr);
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  logic [31:0] rd_word;

  // Status: counter, driven level and the level seen back at the pad
  always_comb begin
    case (rd_idx)
      `MPT_IDX_CTRL:     rd_word = {29'h0, ctrl_r};
      `MPT_IDX_RELOAD:   rd_word = {24'h0, reload_r};
      `MPT_IDX_TMR_RL:   rd_word = {16'h0, tmr_rl_r};
      `MPT_IDX_TMR_CTRL: rd_word = {24'h0, tmr_ctrl_r};
      `MPT_IDX_STATUS:   rd_word = {22'h0, pin_s2_r, pin_r, cnt_r};
      default:           rd_word = 32'h0;
    endcase
  end

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= 2'h0;
    end else if (ar_hs) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= idx_ok(rd_idx) ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------- Assertions ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_reset_ctrl_clear: assert property ( // R13
    $past(srst) |-> (ctrl_r == '0))
    else $error("control bits not clear after reset");

  a_start_loads: assert property ( // R7
    start |=> (cnt_r == $past(reload_r)) && ctrl_r.run)
    else $error("start did not load reload value");

  a_count_step: assert property ( // R16
    (ctrl_r.run && tick && cnt_r != 8'h00 && !start && !wr_ctrl)
      |=> (cnt_r == $past(cnt_r) - 8'h01))
    else $error("counter did not step down by one");

  a_mod_uflow_stop: assert property ( // R6
    (uflow && mode == MPT_MOD && !wr_ctrl) |=> !ctrl_r.run && !pin_r)
    else $error("modulator did not stop on underflow");

  a_mod_idle_low: assert property ( // R6
    (mode == MPT_MOD && !ctrl_r.run) |-> !pin_r)
    else $error("modulator pin high while stopped");

  a_half_toggle: assert property ( // R9
    (uflow && mode == MPT_HALF && !wr_ctrl)
      |=> (pin_r != $past(pin_r)) && ctrl_r.run)
    else $error("half mode pin did not toggle");

  a_var_start: assert property ( // R10
    var_set |=> ctrl_r.run && pin_r && (cnt_r == $past(reload_r)))
    else $error("timer underflow did not start pulse");

  a_var_end: assert property ( // R11
    (uflow && mode == MPT_VAR && !var_set && !wr_ctrl)
      |=> !ctrl_r.run && !pin_r)
    else $error("variable duty pulse did not end");

  a_tc_period: assert property ( // R4
    tc_tick |=> !tc_tick ##9 tc_tick)
    else $error("instruction tick period is not ten");

  a_clear_stops: assert property ( // R8
    (wr_ctrl && !wr_data[`MPT_BIT_RUN] && !var_set)
      |=> !ctrl_r.run ##1 ((cnt_r == $past(cnt_r)) || $past(var_set)))
    else $error("clearing run did not stop counter");

  a_oe_forced: assert property ( // R2
    (mode != MPT_IO) |-> mod_out_pin_oe)
    else $error("pad not driven in a timer mode");

  a_io_follows: assert property ( // R13
    (mode == MPT_IO && !wr_ctrl)
      |=> (pin_r == $past(gpio_o)) && (oe_r == $past(gpio_oe)))
    else $error("plain I/O pin does not follow gpio");

  a_var_hold_low: assert property ( // R11
    (mode == MPT_VAR && !ctrl_r.run && !var_set && !wr_ctrl)
      |=> !pin_r)
    else $error("variable duty pin high while stopped");

  a_half_keeps_run: assert property ( // R9
    (mode == MPT_HALF && !wr_ctrl) |=> ctrl_r.run)
    else $error("half mode stopped by itself");

  c_mod_burst: cover property (uflow && mode == MPT_MOD);
  c_tc_burst: cover property (uflow && mode == MPT_MOD && !ctrl_r.clk_sel);
  c_half_wave: cover property (uflow && mode == MPT_HALF);
  c_var_pulse: cover property (var_set ##[1:600] (uflow && mode == MPT_VAR));
endmodule
`default_nettype wire

// file: verif/mpt_pin_model.sv
// Load on the modulator pin: resolves the pad level and measures pulses.
// Assumes one clock; pin_oe high means the block drives the pad.
`timescale 1ns/1ps
`default_nettype none
module mpt_pin_model (
  input  wire logic clk,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output logic      pin_lvl,
  output int        high_len,
  output int        period,
  output int        rises
);
  logic last_r = 1'b0;
  logic drv_r  = 1'b0;
  int   hi_cnt = 0;
  int   since  = 0;
  int   hl_r   = 0;
  int   per_r  = 0;
  int   rise_r = 0;
  // No pull on the pad: an undriven pin rests at the inverse of the level
  // last driven, a steady step rather than a free-running toggle
  assign pin_lvl  = pin_oe ? pin_o : ~drv_r;
  assign high_len = hl_r;
  assign period   = per_r;
  assign rises    = rise_r;
  always @(posedge clk) begin
    if (pin_oe) drv_r <= pin_o;
    last_r <= pin_lvl;
    since <= (pin_lvl && !last_r) ? 1 : since + 1;
    hi_cnt <= pin_lvl ? hi_cnt + 1 : 0;
    if (pin_lvl && !last_r) begin
      rise_r <= rise_r + 1;
      per_r <= since;
    end
    if (!pin_lvl && last_r) begin
      hl_r <= hi_cnt;
    end
  end
endmodule
`default_nettype wire

// file: verif/modulator_pwm_timer_test.sv
// Self-checking bench for mpt_top over AXI4-Lite.
// Assumes a 100 MHz clock and the register map of mpt_regs.svh.
`timescale 1ns/1ps
`default_nettype none
module modulator_pwm_timer_test;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rd;
  logic [31:0] s1;
  logic [1:0]  rs;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        gpio_o = 1'b0;
  logic        gpio_oe = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid;
  wire logic   pin_o, pin_oe, pin_lvl, timer_io_pin;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int          err_total = 0;
  int          samples_checked = 0;
  int          high_len, period, rises, k, r0;

  always #5 clk = ~clk;

  mpt_top mpt_top_inst (.clk(clk), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gpio_o(gpio_o),
    .gpio_oe(gpio_oe), .mod_out_pin_i(pin_lvl), .mod_out_pin_o(pin_o),
    .mod_out_pin_oe(pin_oe), .timer_io_pin_o(timer_io_pin));

  mpt_pin_model mpt_pin_model_inst (.clk(clk), .pin_o(pin_o),
    .pin_oe(pin_oe), .pin_lvl(pin_lvl), .high_len(high_len),
    .period(period), .rises(rises));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Ready is sampled at the falling edge, where it is settled for the next
  // rising edge; everything changes only after that rising edge.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ad, wd, ah, wh;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge clk);
      ah = awready;
      wh = wready;
      @(posedge clk);
      if (ah === 1'b1 && !ad) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (wh === 1'b1 && !wd) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ah = bvalid;
      rs = bresp;
      @(posedge clk);
    end while (ah !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [11:0] a);
    logic h;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge clk);
      h = arready;
      @(posedge clk);
    end while (h !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      h = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge clk);
    end while (h !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Whole run is under a thousand cycles; this leaves ample margin
  initial begin
    #400000;
    err_total++;
    results();
  end

  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdr(12'h330); chk(rd, 32'h0, "ctrl reset");
    rdr(12'h33c); chk(rd, 32'h0, "reload reset");
    rdr(12'h100); chk(rs, 32'h2, "unmapped read");
    wr(12'h100, 32'h1); chk(rs, 32'h2, "unmapped write");
    chk(pin_oe, 32'h0, "io mode oe");
    gpio_oe <= 1'b1;
    gpio_o <= 1'b1;
    cyc(3);
    chk({pin_oe, pin_o}, 32'h3, "io mode follows gpio");
    rdr(12'h348); chk(rd, 32'h300, "pad level in status");
    gpio_o <= 1'b0;
    // Oscillator-clocked burst of four, started twice from one load
    wr(12'h33c, 32'h3);
    rdr(12'h33c); chk(rd, 32'h3, "reload readback");
    r0 = rises;
    for (k = 0; k < 2; k++) begin
      wr(12'h330, 32'h7);
      cyc(20);
      chk(high_len, 32'h4, "osc burst width");
      chk(rises - r0, k + 1, "one burst per start");
      rdr(12'h330); chk(rd, 32'h6, "run cleared");
      chk(pin_o, 32'h0, "pin low after burst");
    end
    // Instruction-clock burst of two
    wr(12'h33c, 32'h1);
    wr(12'h330, 32'h5);
    rdr(12'h330); chk(rd, 32'h5, "tc burst running");
    cyc(30);
    rdr(12'h330); chk(rd, 32'h4, "tc burst ended");
    chk(high_len, 32'h5, "tc burst high phase");
    // Half mode: toggle every third tick
    wr(12'h33c, 32'h2);
    wr(12'h330, 32'h1);
    cyc(150);
    chk(high_len, 32'd30, "half mode high");
    chk(period, 32'd60, "half mode period");
    chk(pin_oe, 32'h1, "mode drives pin");
    wr(12'h330, 32'h0);
    rdr(12'h348);
    s1 = rd;
    cyc(60);
    rdr(12'h348); chk(rd[7:0], s1[7:0], "counter stopped");
    // Variable duty: wide timer every ten ticks, pulse of three ticks
    wr(12'h340, 32'h9);
    wr(12'h344, 32'hb0);
    wr(12'h33c, 32'h2);
    wr(12'h330, 32'h2);
    cyc(350);
    chk(period, 32'd100, "var period");
    chk(high_len >= 29 && high_len <= 31, 32'h1, "var width");
    results();
  end
endmodule
`default_nettype wire
